/* hw/lsmpc_pkg.sv */
// lsmpc_pkg: constants, types and helpers of the lamp switch control core
// ===========================================================================
package lsmpc_pkg;
   localparam logic [4:0]  SPI_CNT_FULL  = 5'h10;
   localparam logic [4:0]  SPI_CNT_OVER  = 5'h11;
   localparam logic [15:0] STATUS_RESET  = 16'h0000;
   localparam int          WD_BIT_POS    = 15;
   localparam int          EXIT_BIT_POS  = 14;
   localparam logic [15:0] CAL_CMD_WORD  = 16'hC0A5;
   localparam logic [9:0]  SYNC_RESET    = 10'h001;
   localparam int          PWM_SHIFT     = 7;
   localparam logic [6:0]  DUTY_FULL     = 7'h7F;
   localparam logic [3:0]  DELAY_LSB     = 4'h0;
   localparam int          CNT_W         = 24;
   localparam int          PER_W         = 17;
   localparam int          CLK_PERIOD_NS = 10;
   localparam int          INT_TICK_NS   = 39060;
   localparam logic [PER_W-1:0] INT_PERIOD_RESET =
      PER_W'(INT_TICK_NS / CLK_PERIOD_NS);

   typedef enum logic [1:0] {
      MODE_SLEEP, MODE_NORMAL, MODE_FAILSAFE, MODE_FAULT
   } lsmpc_mode_t;

   // duty window of one channel, delayed by code times sixteen ticks
   function automatic logic pwm_on(input logic [6:0] cnt,
                                   input logic [6:0] duty,
                                   input logic [2:0] dly);
      logic [6:0] phase;
      phase = cnt - {dly, DELAY_LSB};
      return (duty == DUTY_FULL) || (phase <= duty);
   endfunction : pwm_on
endpackage : lsmpc_pkg

/* hw/lsmpc_top.sv */
// lsmpc_top: serial port, mode decision, output drive and PWM of the core
`timescale 1ns/10ps
module lsmpc_top
   import lsmpc_pkg::*;
#(
   parameter logic [CNT_W-1:0] EXT_GAP_MIN = 24'h000064,
   parameter logic [CNT_W-1:0] EXT_GAP_MAX = 24'h002710,
   parameter logic [CNT_W-1:0] CAL_MIN     = 24'h004E20,
   parameter logic [CNT_W-1:0] CAL_MAX     = 24'h0F4240
) (
   input  wire logic        CLK,
   input  wire logic        RST_N,
   input  wire logic        CS_N,
   input  wire logic        SCLK,
   input  wire logic        SI,
   output      logic        SO,
   output      logic        SO_OE,
   input  wire logic [15:0] STATUS_WORD,
   output      logic [15:0] RX_WORD,
   output      logic        RX_VALID,
   input  wire logic        RESET_PIN,
   input  wire logic        WAKE_PIN,
   input  wire logic [3:0]  PARALLEL_IN,
   input  wire logic [3:0]  IN_ACTIVE,
   input  wire logic        WATCHDOG_MODE_SELECT,
   input  wire logic        LOGIC_SUPPLY_FAIL,
   input  wire logic        SUPPLY_FAIL_DETECT_EN,
   input  wire logic        WATCHDOG_TIMEOUT,
   input  wire logic [3:0]  OVERCURRENT_FLAGS,
   input  wire logic [3:0]  OVERTEMP_FLAGS,
   input  wire logic [3:0]  SEVERE_SHORT_FLAGS,
   input  wire logic        LOW_SUPPLY_FLAG,
   input  wire logic        EXCESS_SUPPLY_FLAG,
   input  wire logic        EXCESS_SUPPLY_FAULT_GATE,
   input  wire logic [3:0]  CHANNEL_ENABLE,
   input  wire logic [3:0]  DIRECT_BLOCK,
   input  wire logic        PWM_ENABLE,
   input  wire logic        CLOCK_SOURCE,
   input  wire logic [27:0] DUTY_CODES,
   input  wire logic [11:0] DELAY_CODES,
   output      logic [3:0]  POWER_OUTPUTS,
   output      logic [3:0]  FAULT_CLEAR,
   output      lsmpc_mode_t MODE,
   output      logic        NORMAL_MODE_FLAG,
   output      logic        CLOCK_FAIL_FLAG,
   output      logic        WATCHDOG_RUN,
   output      logic        AUTORETRY_ACTIVE,
   output      logic        FAULT_LATCH_RESET,
   output      logic        WATCHDOG_KICK,
   output      logic        CAL_VALID
);
   // ========================================================================
   // pin synchronisers
   logic [9:0] sync1;
   logic [9:0] sync2;
   logic       cs_d;
   logic       sclk_d;
   logic       in0_d;
   wire        cs_s   = sync2[0];
   wire        sclk_s = sync2[1];
   wire        si_s   = sync2[2];
   wire [3:0]  in_s   = sync2[6:3];
   wire        rst_s  = sync2[7];
   wire        wake_s = sync2[8];
   wire        fsi_s  = sync2[9];

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         sync1 <= SYNC_RESET;
         sync2 <= SYNC_RESET;
         cs_d  <= 1'b1;
         sclk_d <= 1'b0;
         in0_d <= 1'b0;
      end else begin
         sync1 <= {WATCHDOG_MODE_SELECT, WAKE_PIN, RESET_PIN, PARALLEL_IN,
                   SI, SCLK, CS_N};
         sync2 <= sync1;
         cs_d  <= cs_s;
         sclk_d <= sclk_s;
         in0_d <= in_s[0];
      end
   end

   // ========================================================================
   // serial port
   logic [15:0] tx_shift;
   logic [15:0] rx_shift;
   logic [4:0]  bit_cnt;
   logic        last_wd;
   wire cs_fall   = cs_d & ~cs_s;
   wire cs_rise   = ~cs_d & cs_s;
   wire sclk_rise = ~cs_s & ~sclk_d & sclk_s;
   wire sclk_fall = ~cs_s & sclk_d & ~sclk_s;
   // short or long frames are dropped whole
   wire rx_done   = cs_rise & (bit_cnt == SPI_CNT_FULL);
   wire exit_cmd  = rx_done & rx_shift[EXIT_BIT_POS];
   wire fail;
   // an exit word in Fail-safe carries nothing else
   wire rx_pass   = rx_done & ~(exit_cmd & fail);
   wire cal_cmd   = rx_pass & (rx_shift == CAL_CMD_WORD);

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         tx_shift <= STATUS_RESET;
         rx_shift <= STATUS_RESET;
         bit_cnt  <= 5'h00;
         SO       <= 1'b0;
         SO_OE    <= 1'b0;
         RX_WORD  <= STATUS_RESET;
         RX_VALID <= 1'b0;
         last_wd  <= 1'b0;
         WATCHDOG_KICK <= 1'b0;
      end else begin
         SO_OE    <= ~cs_s;
         RX_VALID <= rx_pass;
         WATCHDOG_KICK <= rx_pass & (rx_shift[WD_BIT_POS] != last_wd);
         if (rx_pass) begin
            RX_WORD <= rx_shift;
            last_wd <= rx_shift[WD_BIT_POS];
         end
         if (cs_fall) begin
            tx_shift <= STATUS_WORD;
            bit_cnt  <= 5'h00;
         end else if (sclk_rise) begin
            SO       <= tx_shift[15];
            tx_shift <= {tx_shift[14:0], 1'b0};
         end
         if (sclk_fall) begin
            rx_shift <= {rx_shift[14:0], si_s};
            if (bit_cnt != SPI_CNT_OVER)
               bit_cnt <= bit_cnt + 5'h01;
         end
      end
   end

   // ========================================================================
   // mode decision
   logic fail_hold;
   wire  wake = rst_s | wake_s | (|IN_ACTIVE);
   wire  fail_cond = (LOGIC_SUPPLY_FAIL & SUPPLY_FAIL_DETECT_EN) |
                     (WATCHDOG_TIMEOUT & fsi_s);
   wire [3:0] faulted = OVERCURRENT_FLAGS | OVERTEMP_FLAGS |
                        SEVERE_SHORT_FLAGS;
   wire  fault_cond = (|faulted) | LOW_SUPPLY_FLAG |
                      (EXCESS_SUPPLY_FLAG & EXCESS_SUPPLY_FAULT_GATE);
   // a new failure in the exit cycle keeps Fail-safe
   wire  next_fail_hold = wake & (fail_cond | (fail_hold & ~exit_cmd));
   assign fail = fail_cond | fail_hold;
   lsmpc_mode_t next_mode;
   assign next_mode = !wake      ? MODE_SLEEP :
                      fault_cond ? MODE_FAULT :
                      fail       ? MODE_FAILSAFE :
                                   MODE_NORMAL;
   wire  swap = ((MODE == MODE_NORMAL) && (next_mode == MODE_FAILSAFE)) ||
                ((MODE == MODE_FAILSAFE) && (next_mode == MODE_NORMAL));

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         fail_hold <= 1'b0;
         MODE      <= MODE_SLEEP;
         NORMAL_MODE_FLAG  <= 1'b0;
         WATCHDOG_RUN      <= 1'b0;
         AUTORETRY_ACTIVE  <= 1'b0;
         FAULT_LATCH_RESET <= 1'b0;
      end else begin
         fail_hold <= next_fail_hold;
         MODE      <= next_mode;
         NORMAL_MODE_FLAG  <= (next_mode == MODE_NORMAL);
         WATCHDOG_RUN      <= (next_mode == MODE_NORMAL) & fsi_s;
         AUTORETRY_ACTIVE  <= (next_mode == MODE_FAULT);
         FAULT_LATCH_RESET <= swap | (exit_cmd & fail);
      end
   end

   // ========================================================================
   // settings as seen by the logic, zero while asleep
   wire        awake   = (MODE != MODE_SLEEP);
   wire [3:0]  en      = CHANNEL_ENABLE & {4{awake}};
   wire [3:0]  blk     = DIRECT_BLOCK & {4{awake}};
   wire        pwm_en  = PWM_ENABLE & awake;
   wire        clk_sel = CLOCK_SOURCE & awake;
   wire [27:0] duty    = DUTY_CODES & {28{awake}};
   wire [11:0] dly     = DELAY_CODES & {12{awake}};

   // ========================================================================
   // PWM reference: external edge or calibrated internal divider
   logic [PER_W-1:0] cal_period;
   logic [PER_W-1:0] int_cnt;
   logic [CNT_W-1:0] gap_cnt;
   logic [CNT_W-1:0] cal_cnt;
   logic             cal_armed;
   logic             cal_meas;
   logic [6:0]       pwm_cnt;
   wire ext_tick = in_s[0] & ~in0_d;
   wire int_tick = (int_cnt >= cal_period - 17'h00001);
   wire pwm_tick = clk_sel ? int_tick : ext_tick;
   wire gap_long = (gap_cnt >= EXT_GAP_MAX);
   wire clk_bad  = CLOCK_FAIL_FLAG & ~clk_sel;
   wire pwm_run  = pwm_en & ~clk_bad;
   wire cal_ok   = (cal_cnt >= CAL_MIN) && (cal_cnt <= CAL_MAX);
   wire cal_end  = cal_meas & cs_rise;

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         cal_period <= INT_PERIOD_RESET;
         CAL_VALID  <= 1'b0;
      end else if (cal_end && cal_ok) begin
         cal_period <= cal_cnt[CNT_W-1:PWM_SHIFT];
         CAL_VALID  <= 1'b1;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N || !awake) begin
         int_cnt   <= '0;
         gap_cnt   <= '0;
         cal_cnt   <= '0;
         cal_armed <= 1'b0;
         cal_meas  <= 1'b0;
         pwm_cnt   <= 7'h00;
         CLOCK_FAIL_FLAG <= 1'b0;
      end else begin
         int_cnt <= int_tick ? '0 : int_cnt + 17'h00001;
         if (ext_tick) begin
            gap_cnt <= '0;
            CLOCK_FAIL_FLAG <= (gap_cnt < EXT_GAP_MIN);
         end else if (gap_long) begin
            CLOCK_FAIL_FLAG <= 1'b1;
         end else begin
            gap_cnt <= gap_cnt + 24'h000001;
         end
         // a rejected pulse just disarms, period untouched
         if (cal_end) begin
            cal_meas  <= 1'b0;
            cal_armed <= 1'b0;
         end else if (cal_armed && cs_fall) begin
            cal_meas  <= 1'b1;
            // the fall cycle is the first low cycle of the pulse
            cal_cnt   <= 24'h000001;
         end else if (cal_cmd) begin
            cal_armed <= 1'b1;
         end
         if (cal_meas && cal_cnt != CAL_MAX + 24'h000001)
            cal_cnt <= cal_cnt + 24'h000001;
         if (!pwm_run)
            pwm_cnt <= 7'h00;
         else if (pwm_tick)
            pwm_cnt <= pwm_cnt + 7'h01;
      end
   end

   // ========================================================================
   // per-channel drive
   logic [3:0] wave;
   logic [3:0] hson;
   logic [3:0] fclr;
   genvar ch;
   for (ch = 0; ch < 4; ch++) begin : g_ch
      assign wave[ch] = pwm_on(pwm_cnt, duty[7*ch +: 7],
                               dly[3*ch +: 3]);
      assign hson[ch] = pwm_en ?
         (en[ch] & (clk_bad | wave[ch])) :
         (en[ch] | (in_s[ch] & ~blk[ch]));
      assign fclr[ch] = en[ch] |
         (IN_ACTIVE[ch] & ~blk[ch] & ~pwm_en);
   end
   wire [3:0] base = fail ? in_s : hson;
   wire [3:0] next_out =
      (MODE == MODE_NORMAL)   ? hson :
      (MODE == MODE_FAILSAFE) ? in_s :
      (MODE == MODE_FAULT)    ? (base & ~faulted) :
                                4'h0;

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         POWER_OUTPUTS <= 4'h0;
         FAULT_CLEAR   <= 4'h0;
      end else begin
         POWER_OUTPUTS <= next_out;
         FAULT_CLEAR   <= awake ? fclr : 4'h0;
      end
   end

   // ========================================================================
   // checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   sequence s_cal_cmd;
      cal_cmd;
   endsequence
   sequence s_cal_good;
      cal_end && cal_ok;
   endsequence

   a_so_tristate: assert property (cs_s |=> !SO_OE)
      else $error("serial output enabled with chip select high");
   a_so_rise: assert property (sclk_rise |=> SO == $past(tx_shift[15]))
      else $error("serial output not updated on rising clock");
   a_rx_word: assert property (rx_pass |=>
      RX_VALID && RX_WORD == $past(rx_shift))
      else $error("received word not taken at frame end");
   a_rx_short: assert property (cs_rise && bit_cnt != SPI_CNT_FULL
      |=> !RX_VALID)
      else $error("partial frame accepted");
   a_sleep_off: assert property (!wake |=> ##1 POWER_OUTPUTS == 4'h0)
      else $error("outputs on without wake");
   a_fault_mode: assert property (wake && fault_cond
      |=> MODE == MODE_FAULT && AUTORETRY_ACTIVE)
      else $error("fault condition did not give Fault mode");
   a_fail_follow: assert property (MODE == MODE_FAILSAFE
      |=> POWER_OUTPUTS == $past(in_s))
      else $error("Fail-safe outputs do not follow inputs");
   a_normal_flag: assert property (NORMAL_MODE_FLAG
      == (MODE == MODE_NORMAL))
      else $error("normal flag disagrees with mode");
   a_duty_full: assert property (
      MODE == MODE_NORMAL && pwm_run && en[1] && duty[13:7] == DUTY_FULL
      |=> POWER_OUTPUTS[1])
      else $error("full duty code not fully on");
   a_clk_lost: assert property (awake && gap_long && !ext_tick
      |=> CLOCK_FAIL_FLAG)
      else $error("lost external clock not flagged");
   a_cal_take: assert property (s_cal_good
      |=> cal_period == $past(cal_cnt[CNT_W-1:PWM_SHIFT]))
      else $error("good calibration pulse not applied");
   a_cal_drop: assert property (cal_end && !cal_ok
      |=> $stable(cal_period))
      else $error("bad calibration pulse changed period");
   a_cal_arm: assert property (
      (s_cal_cmd and awake) |=> cal_armed)
      else $error("calibration word did not arm");
   a_sleep_clear: assert property (MODE == MODE_SLEEP
      |=> pwm_cnt == 7'h00 && !cal_armed && !cal_meas)
      else $error("PWM state not cleared in Sleep");
   a_pwm_gate: assert property (MODE == MODE_NORMAL && pwm_en
      |=> (POWER_OUTPUTS & ~$past(en)) == 4'h0)
      else $error("PWM drove a disabled channel");
   a_sleep_zero: assert property (MODE == MODE_SLEEP
      |=> FAULT_CLEAR == 4'h0)
      else $error("fault clear active in Sleep");
   a_exit_pulse: assert property (exit_cmd && fail
      |=> FAULT_LATCH_RESET && !RX_VALID)
      else $error("exit word did not clear latched faults");
   a_mode_fail: assert property (wake && fail && !fault_cond
      |=> MODE == MODE_FAILSAFE)
      else $error("fail condition did not give Fail-safe mode");
endmodule : lsmpc_top

/* verification/lsmpc_host.sv */
// lsmpc_host: behavioural serial bus master on the far side of the core
`timescale 1ns/10ps
module lsmpc_host (
   input  wire logic clk,
   input  wire logic so_line,
   output logic      cs_n,
   output logic      sclk,
   output logic      si
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      si   = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   // ========================================================================
   // frame
   // phases of 6 clk: the core needs at least 4 per phase behind its syncs
   task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
      tick(1);
      cs_n <= 1'b0;
      tick(6);
      for (int i = 15; i >= 0; i--) begin
         si   <= tx[i];
         sclk <= 1'b1;
         tick(6);
         sclk <= 1'b0;
         rx[i] = so_line;
         tick(6);
      end
      cs_n <= 1'b1;
      si   <= 1'b0; // released line falls to its pull-down
      tick(8);
   endtask : xfer

   // ========================================================================
   // timed chip-select pulse, n clk long
   task automatic low_pulse(input int n);
      tick(1);
      cs_n <= 1'b0;
      tick(n);
      cs_n <= 1'b1;
      tick(8);
   endtask : low_pulse
endmodule : lsmpc_host

/* verification/lsmpc_bench.sv */
// lsmpc_bench: self-checking testbench of the lamp switch control core
`timescale 1ns/10ps
module lsmpc_bench
   import lsmpc_pkg::*;
;
   logic CLK, RST_N, CS_N, SCLK, SI, SO, SO_OE, RX_VALID, RESET_PIN, WAKE_PIN;
   logic WATCHDOG_MODE_SELECT, LOGIC_SUPPLY_FAIL, SUPPLY_FAIL_DETECT_EN;
   logic WATCHDOG_TIMEOUT, LOW_SUPPLY_FLAG, EXCESS_SUPPLY_FLAG, PWM_ENABLE;
   logic EXCESS_SUPPLY_FAULT_GATE, CLOCK_SOURCE, NORMAL_MODE_FLAG, CAL_VALID;
   logic CLOCK_FAIL_FLAG, WATCHDOG_RUN, AUTORETRY_ACTIVE, FAULT_LATCH_RESET;
   logic WATCHDOG_KICK, got_rx, got_flr, got_kick, ext_on;
   logic [15:0] STATUS_WORD, RX_WORD, rx;
   logic [3:0]  PARALLEL_IN, IN_ACTIVE, OVERCURRENT_FLAGS, OVERTEMP_FLAGS;
   logic [3:0]  SEVERE_SHORT_FLAGS, CHANNEL_ENABLE, DIRECT_BLOCK, FAULT_CLEAR;
   logic [3:0]  POWER_OUTPUTS;
   logic [27:0] DUTY_CODES;
   logic [11:0] DELAY_CODES;
   lsmpc_mode_t MODE;
   int          n_mismatch, check_count, cnt[4], r0, r3, ext_div;
   // a released data line reads inverted, so a late sample shows up
   wire         so_line = SO_OE ? SO : ~SO;
   // external PWM reference on channel 0, one rise every ten clk
   wire [3:0]   par_in  = ext_on ? {PARALLEL_IN[3:1], ext_div < 5} :
                          PARALLEL_IN;

   lsmpc_top #(.EXT_GAP_MIN(24'h000004), .EXT_GAP_MAX(24'h000040),
      .CAL_MIN(24'h000100), .CAL_MAX(24'h001000)) uut (.CLK, .RST_N, .CS_N,
      .SCLK, .SI, .SO, .SO_OE, .STATUS_WORD, .RX_WORD, .RX_VALID, .RESET_PIN,
      .WAKE_PIN, .PARALLEL_IN(par_in), .IN_ACTIVE, .WATCHDOG_MODE_SELECT,
      .LOGIC_SUPPLY_FAIL, .SUPPLY_FAIL_DETECT_EN, .WATCHDOG_TIMEOUT,
      .OVERCURRENT_FLAGS, .OVERTEMP_FLAGS, .SEVERE_SHORT_FLAGS,
      .LOW_SUPPLY_FLAG, .EXCESS_SUPPLY_FLAG, .EXCESS_SUPPLY_FAULT_GATE,
      .CHANNEL_ENABLE, .DIRECT_BLOCK, .PWM_ENABLE, .CLOCK_SOURCE, .DUTY_CODES,
      .DELAY_CODES, .POWER_OUTPUTS, .FAULT_CLEAR, .MODE, .NORMAL_MODE_FLAG,
      .CLOCK_FAIL_FLAG, .WATCHDOG_RUN, .AUTORETRY_ACTIVE, .FAULT_LATCH_RESET,
      .WATCHDOG_KICK, .CAL_VALID);

   lsmpc_host host (.clk(CLK), .so_line(so_line), .cs_n(CS_N), .sclk(SCLK),
      .si(SI));

   always #5 CLK = ~CLK;

   // one-cycle pulses are caught here so that frame tasks need not race them
   always @(posedge CLK) begin
      if (RX_VALID === 1'b1) got_rx <= 1'b1;
      if (FAULT_LATCH_RESET === 1'b1) got_flr <= 1'b1;
      if (WATCHDOG_KICK === 1'b1) got_kick <= 1'b1;
      ext_div <= (ext_div == 9) ? 0 : ext_div + 1;
   end

   // ========================================================================
   // compare, wait and report
   task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_val

   task automatic check_cnt(input int got, input int exp);
      check_count++;
      if (got != exp) begin
         n_mismatch++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_cnt

   task automatic settle(input int n);
      repeat (n) @(posedge CLK);
   endtask : settle

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : give_verdict

   // one full PWM period of 1280 clk: on-times and rise positions
   task automatic measure();
      logic [3:0] prev;
      prev = POWER_OUTPUTS;
      cnt = '{0, 0, 0, 0};
      for (int t = 0; t < 1280; t++) begin
         @(posedge CLK);
         for (int c = 0; c < 4; c++) cnt[c] += int'(POWER_OUTPUTS[c]);
         if (POWER_OUTPUTS[0] & ~prev[0]) r0 = t;
         if (POWER_OUTPUTS[3] & ~prev[3]) r3 = t;
         prev = POWER_OUTPUTS;
      end
   endtask : measure

   initial begin
      repeat (60000) @(posedge CLK);
      n_mismatch++;
      give_verdict();
   end

   // ========================================================================
   // main sequence
   initial begin
      CLK = 0; RST_N = 0; RESET_PIN = 0; WAKE_PIN = 0; PARALLEL_IN = 0;
      IN_ACTIVE = 0; WATCHDOG_MODE_SELECT = 0; LOGIC_SUPPLY_FAIL = 0;
      SUPPLY_FAIL_DETECT_EN = 0; WATCHDOG_TIMEOUT = 0; OVERCURRENT_FLAGS = 0;
      OVERTEMP_FLAGS = 0; SEVERE_SHORT_FLAGS = 0; LOW_SUPPLY_FLAG = 0;
      EXCESS_SUPPLY_FLAG = 0; EXCESS_SUPPLY_FAULT_GATE = 0; PWM_ENABLE = 0;
      CHANNEL_ENABLE = 0; DIRECT_BLOCK = 0; CLOCK_SOURCE = 0; DUTY_CODES = 0;
      DELAY_CODES = 0; STATUS_WORD = 16'hA55A; got_rx = 0; got_flr = 0;
      got_kick = 0; n_mismatch = 0; check_count = 0; r0 = 0; r3 = 0;
      ext_on = 0; ext_div = 0;
      settle(5);
      RST_N <= 1'b1;
      settle(2);
      check_val(16'(MODE), 16'(MODE_SLEEP));
      check_val(16'(SO_OE), 16'h0000);
      for (int k = 0; k < 6; k++) begin
         RESET_PIN <= (k == 5);
         WAKE_PIN <= (k == 4);
         IN_ACTIVE <= 4'(1 << k);
         settle(6);
         check_val(16'(MODE), 16'(MODE_NORMAL));
         check_val(16'(NORMAL_MODE_FLAG), 16'h0001);
         check_val(16'(WATCHDOG_RUN), 16'h0000);
         RESET_PIN <= 1'b0;
         WAKE_PIN <= 1'b0;
         IN_ACTIVE <= 4'h0;
         settle(6);
         check_val(16'(MODE), 16'(MODE_SLEEP));
      end
      WAKE_PIN <= 1'b1; CHANNEL_ENABLE <= 4'h1; PARALLEL_IN <= 4'hA;
      DIRECT_BLOCK <= 4'h8; IN_ACTIVE <= 4'h6;
      settle(6);
      check_val(16'(POWER_OUTPUTS), 16'h0003);
      check_val(16'(FAULT_CLEAR), 16'h0007);
      host.xfer(16'h8001, rx);
      check_val(rx, 16'hA55A);
      check_val(RX_WORD, 16'h8001);
      check_val(16'(got_rx), 16'h0001);
      STATUS_WORD <= 16'h1234;
      got_kick = 1'b0;
      host.xfer(16'h0002, rx);
      check_val(rx, 16'h1234);
      check_val(16'(got_kick), 16'h0001);
      WATCHDOG_MODE_SELECT <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         WATCHDOG_TIMEOUT <= (k == 0);
         LOGIC_SUPPLY_FAIL <= (k == 1);
         SUPPLY_FAIL_DETECT_EN <= 1'(k);
         settle(6);
         check_val(16'(MODE), 16'(MODE_FAILSAFE));
         check_val(16'(POWER_OUTPUTS), 16'h000A);
         WATCHDOG_TIMEOUT <= 1'b0;
         LOGIC_SUPPLY_FAIL <= 1'b0;
         got_flr = 1'b0;
         got_rx = 1'b0;
         host.xfer(16'h4000, rx);
         settle(2);
         check_val(16'(got_flr), 16'h0001);
         check_val(16'(got_rx), 16'h0000);
         check_val(16'(MODE), 16'(MODE_NORMAL));
         check_val(16'(WATCHDOG_RUN), 16'h0001);
      end
      EXCESS_SUPPLY_FLAG <= 1'b1;
      settle(4);
      check_val(16'(MODE), 16'(MODE_NORMAL));
      for (int k = 0; k < 5; k++) begin
         OVERCURRENT_FLAGS <= (k == 0) ? 4'h1 : 4'h0;
         OVERTEMP_FLAGS <= (k == 1) ? 4'h2 : 4'h0;
         SEVERE_SHORT_FLAGS <= (k == 2) ? 4'hC : 4'h0;
         LOW_SUPPLY_FLAG <= (k == 3);
         EXCESS_SUPPLY_FAULT_GATE <= (k == 4);
         settle(4);
         check_val(16'(MODE), 16'(MODE_FAULT));
         check_val(16'(AUTORETRY_ACTIVE), 16'h0001);
         check_val(16'(POWER_OUTPUTS), (k == 0) ? 16'h0002 :
                   (k == 1) ? 16'h0001 : 16'h0003);
         OVERCURRENT_FLAGS <= 4'h0;
         OVERTEMP_FLAGS <= 4'h0;
         SEVERE_SHORT_FLAGS <= 4'h0;
         LOW_SUPPLY_FLAG <= 1'b0;
         EXCESS_SUPPLY_FAULT_GATE <= 1'b0;
         settle(4);
      end
      EXCESS_SUPPLY_FLAG <= 1'b0; CLOCK_SOURCE <= 1'b1; PARALLEL_IN <= 4'hF;
      host.xfer(CAL_CMD_WORD, rx);
      host.low_pulse(1280);
      settle(2);
      check_val(16'(CAL_VALID), 16'h0001);
      DUTY_CODES <= {7'h1F, 7'h40, 7'h7F, 7'h1F}; DELAY_CODES <= 12'hE00;
      CHANNEL_ENABLE <= 4'hB; PWM_ENABLE <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         settle(1300);
         measure();
         check_cnt(cnt[0], 320);
         check_cnt(cnt[1], 1280);
         check_cnt(cnt[2], 0);
         check_cnt((r3 - r0 + 1280) % 1280, 1120);
         host.xfer(CAL_CMD_WORD, rx);
         host.low_pulse(100);
      end
      CLOCK_SOURCE <= 1'b0;
      ext_on <= 1'b1;
      settle(1300);
      check_val(16'(CLOCK_FAIL_FLAG), 16'h0000);
      measure();
      check_cnt(cnt[0], 320);
      check_cnt(cnt[1], 1280);
      check_cnt((r3 - r0 + 1280) % 1280, 1120);
      ext_on <= 1'b0;
      settle(100);
      check_val(16'(CLOCK_FAIL_FLAG), 16'h0001);
      check_val(16'(POWER_OUTPUTS), 16'h000B);
      RESET_PIN <= 1'b0;
      WAKE_PIN <= 1'b0;
      IN_ACTIVE <= 4'h0;
      settle(6);
      check_val(16'(POWER_OUTPUTS), 16'h0000);
      check_val(16'(FAULT_CLEAR), 16'h0000);
      give_verdict();
   end
endmodule : lsmpc_bench
